// File: hw/sbt_pkg.sv
// Functional notes
// RL1 - both buttons held 8 s: fault recall, tag
// RL2 - advance shows stored faults, oldest first
// RL3 - test press leaves recall to main menu
// RL4 - test held 1 s then released: test mode
// RL5 - test entry clears anti-short-cycle timer
// RL6 - test mode runs unit without demand
// RL7 - demand with timer: show t, then run steady
// RL8 - demand at test end keeps unit running
// RL9 - no demand: steady C, compressor 5 s
// RL10 - heating 1 s press: timed defrost cycle
// RL11 - defrost test only when coil below 70F
// RL12 - defrost running shows defrost letter
// RL13 - test press ends defrost test at once
// RL14 - heating 5 s hold: continuous defrost until press
// RL15 - steady letter c C h H per demand
// RL16 - demand during timers flashes the letter
// RL17 - no demand shows standby zero
// RL18 - debounce, time hold, decode on release
package sbt_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_NS       = 4;
   localparam int unsigned TICK_NS      = 1_000_000;
   localparam int unsigned TICK_CYC     = TICK_NS / CLK_NS;
   localparam int unsigned TICK_MS      = 1;
   localparam int unsigned FC_HOLD_MS   = 8000;
   localparam int unsigned TEST_HOLD_MS = 1000;
   localparam int unsigned CONT_HOLD_MS = 5000;
   localparam int unsigned RUN_MS       = 5000;
   localparam int unsigned DEF_MAX_MIN  = 14;
   localparam int unsigned ASC_MIN      = 3;
   localparam int unsigned MINRUN_S     = 30;
   localparam int unsigned SHOW_MS      = 500;
   localparam int unsigned BLINK_MS     = 500;
   localparam int unsigned FC_HOLD_T    = FC_HOLD_MS / TICK_MS;
   localparam int unsigned TEST_HOLD_T  = TEST_HOLD_MS / TICK_MS;
   localparam int unsigned CONT_HOLD_T  = CONT_HOLD_MS / TICK_MS;
   localparam int unsigned RUN_T        = RUN_MS / TICK_MS;
   localparam int unsigned DEF_MAX_T    = DEF_MAX_MIN * 60_000 / TICK_MS;
   localparam int unsigned ASC_T        = ASC_MIN * 60_000 / TICK_MS;
   localparam int unsigned MINRUN_T     = MINRUN_S * 1000 / TICK_MS;
   localparam int unsigned SHOW_T       = SHOW_MS / TICK_MS;
   localparam int unsigned BLINK_T      = BLINK_MS / TICK_MS;
   localparam int unsigned TICK_W       = 18;
   localparam int unsigned CNT_W        = 20;
   // ==========================================================
   // coil and history
   localparam logic [7:0]  COIL_EN_F    = 8'h46;
   localparam logic [7:0]  COIL_TERM_F  = 8'h39;
   localparam int unsigned FAULT_DEPTH  = 8;
   localparam int unsigned PTR_W        = 3;
   // ==========================================================
   // registers, byte addresses
   localparam logic [4:0] REG_STATUS  = 5'h00;
   localparam logic [4:0] REG_DISP    = 5'h04;
   localparam logic [4:0] REG_FPUSH   = 5'h08;
   localparam logic [4:0] REG_FCOUNT  = 5'h0C;
   localparam logic [4:0] REG_IRQ_ST  = 5'h10;
   localparam logic [4:0] REG_IRQ_EN  = 5'h14;
   localparam logic [4:0] REG_IRQ_CLR = 5'h18;
   localparam int unsigned IRQ_W      = 5;
   localparam int unsigned IRQ_RECALL = 0;
   localparam int unsigned IRQ_TEST   = 1;
   localparam int unsigned IRQ_DEF    = 2;
   localparam int unsigned IRQ_REFUSE = 3;
   localparam int unsigned IRQ_DEFEND = 4;
   // ==========================================================
   // display characters
   localparam logic [7:0] CH_F     = 8'h46;
   localparam logic [7:0] CH_UC    = 8'h43;
   localparam logic [7:0] CH_LC    = 8'h63;
   localparam logic [7:0] CH_UH    = 8'h48;
   localparam logic [7:0] CH_LH    = 8'h68;
   localparam logic [7:0] CH_T     = 8'h74;
   localparam logic [7:0] CH_D     = 8'h64;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [7:0] CH_ALPHA = 8'h37;
   localparam logic [7:0] CH_BLANK = 8'h20;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      MD_MAIN, MD_RECALL, MD_TEST_SHOW, MD_TEST_RUN, MD_DEF_TIMED, MD_DEF_CONT
   } sbt_mode_t;

   typedef struct packed {
      logic cool2;
      logic cool1;
      logic heat2;
      logic heat1;
   } sbt_demand_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } sbt_disp_t;

   typedef struct packed {
      sbt_mode_t                        mode;
      logic [TICK_W-1:0]                tick_cnt;
      logic                             tick;
      logic                             raw_a;
      logic                             raw_t;
      logic                             btn_a;
      logic                             btn_t;
      logic                             used_a;
      logic                             used_t;
      logic [CNT_W-1:0]                 hold;
      logic [CNT_W-1:0]                 mtimer;
      logic [CNT_W-1:0]                 asc;
      logic [CNT_W-1:0]                 minrun;
      logic [CNT_W-1:0]                 blink_cnt;
      logic                             blink;
      logic                             comp;
      logic                             fan;
      logic                             defr;
      logic                             rtag;
      logic [PTR_W-1:0]                 ridx;
      logic [FAULT_DEPTH-1:0][7:0]      hist;
      logic [PTR_W-1:0]                 wptr;
      logic [PTR_W:0]                   fcnt;
      sbt_disp_t                        disp;
      logic [IRQ_W-1:0]                 irq_st;
      logic [IRQ_W-1:0]                 irq_en;
      logic                             irq;
      logic                             wr;
      logic [31:0]                      rdata;
   } sbt_state_t;
endpackage

// File: hw/sbt_service_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_service_ctrl #(
   parameter int unsigned TICK_CYC  = sbt_pkg::TICK_CYC,
   parameter int unsigned FC_HOLD   = sbt_pkg::FC_HOLD_T,
   parameter int unsigned CONT_HOLD = sbt_pkg::CONT_HOLD_T,
   parameter int unsigned RUN_T     = sbt_pkg::RUN_T,
   parameter int unsigned DEF_MAX   = sbt_pkg::DEF_MAX_T,
   parameter int unsigned ASC_T     = sbt_pkg::ASC_T,
   parameter int unsigned MINRUN_T  = sbt_pkg::MINRUN_T
) (
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   input  wire logic [4:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   input  wire logic                advance_button,
   input  wire logic                test_button,
   input  wire sbt_pkg::sbt_demand_t demand,
   input  wire logic [7:0]          coil_temp,
   output logic                     comp_on,
   output logic                     fan_on,
   output logic                     defrost_on,
   output sbt_pkg::sbt_disp_t       disp,
   output logic                     irq
);
   sbt_pkg::sbt_state_t         q;
   sbt_pkg::sbt_state_t         s;
   logic                        rel;
   logic                        dem;
   logic                        heat;
   logic                        flash;
   logic [sbt_pkg::IRQ_W-1:0]   ev;
   logic [sbt_pkg::IRQ_W-1:0]   clr;
   logic [sbt_pkg::PTR_W-1:0]   oldest;
   logic [7:0]                  code;

   function automatic logic [7:0] hex_ch(input logic [3:0] n);
      hex_ch = (n < 4'hA) ? sbt_pkg::CH_ZERO + {4'h0, n} : sbt_pkg::CH_ALPHA + {4'h0, n};
   endfunction

   assign dem  = |demand;
   assign heat = demand.heat1 | demand.heat2;

   // ==========================================================
   // next state
   always_comb begin
      s      = q;
      s.tick = 1'b0;
      ev     = '0;
      clr    = '0;
      oldest = q.wptr - q.fcnt[sbt_pkg::PTR_W-1:0];
      code   = q.hist[oldest + q.ridx];
      if (q.tick_cnt == sbt_pkg::TICK_W'(TICK_CYC - 1)) begin
         s.tick_cnt = '0;
         s.tick     = 1'b1;
      end else begin
         s.tick_cnt = q.tick_cnt + 1'b1;
      end
      // RL18 debounce and hold
      if (q.tick) begin
         if (advance_button == q.raw_a) begin
            s.btn_a = advance_button;
         end
         if (test_button == q.raw_t) begin
            s.btn_t = test_button;
         end
         s.raw_a = advance_button;
         s.raw_t = test_button;
         if (s.btn_a | s.btn_t) begin
            if (q.hold != '1) begin
               s.hold = q.hold + 1'b1;
            end
            s.used_a = q.used_a | s.btn_a;
            s.used_t = q.used_t | s.btn_t;
         end
         if (q.asc != '0) s.asc = q.asc - 1'b1;
         if (q.minrun != '0) s.minrun = q.minrun - 1'b1;
         if (q.mtimer != '0) s.mtimer = q.mtimer - 1'b1;
         if (q.blink_cnt == '0) begin
            s.blink_cnt = sbt_pkg::CNT_W'(sbt_pkg::BLINK_T - 1);
            s.blink     = ~q.blink;
         end else begin
            s.blink_cnt = q.blink_cnt - 1'b1;
         end
      end
      rel = q.tick & (q.btn_a | q.btn_t) & ~(s.btn_a | s.btn_t);
      if (rel) begin
         s.hold   = '0;
         s.used_a = 1'b0;
         s.used_t = 1'b0;
      end
      // ==========================================================
      // mode timeouts
      if (q.tick && q.mtimer == sbt_pkg::CNT_W'(1)) begin
         unique case (q.mode)
            // RL7 start after letter
            sbt_pkg::MD_TEST_SHOW: begin
               s.mode   = sbt_pkg::MD_MAIN;
               s.comp   = 1'b1;
               s.minrun = sbt_pkg::CNT_W'(MINRUN_T);
            end
            // RL8 normal logic keeps running on demand
            sbt_pkg::MD_TEST_RUN: s.mode = sbt_pkg::MD_MAIN;
            sbt_pkg::MD_DEF_TIMED: begin
               s.mode             = sbt_pkg::MD_MAIN;
               ev[sbt_pkg::IRQ_DEFEND] = 1'b1;
            end
            default: ;
         endcase
      end
      // RL10 coil termination
      if (q.mode == sbt_pkg::MD_DEF_TIMED && coil_temp >= sbt_pkg::COIL_TERM_F) begin
         s.mode             = sbt_pkg::MD_MAIN;
         ev[sbt_pkg::IRQ_DEFEND] = 1'b1;
      end
      // ==========================================================
      // RL18 decode on release
      if (rel) begin
         if (q.mode == sbt_pkg::MD_RECALL) begin
            // RL3 leave recall
            if (q.used_t) begin
               s.mode = sbt_pkg::MD_MAIN;
            // RL2 step oldest first
            end else if (q.rtag) begin
               s.rtag = 1'b0;
               s.ridx = '0;
            end else if (q.fcnt != '0) begin
               s.ridx = ({1'b0, q.ridx} + 1'b1 == q.fcnt) ? '0 : q.ridx + 1'b1;
            end
         // RL1 recall entry
         end else if (q.used_a && q.used_t && q.hold >= sbt_pkg::CNT_W'(FC_HOLD)) begin
            s.mode             = sbt_pkg::MD_RECALL;
            s.rtag             = 1'b1;
            s.ridx             = '0;
            ev[sbt_pkg::IRQ_RECALL] = 1'b1;
         end else if (q.used_t && !q.used_a) begin
            // RL13 RL14 test press ends defrost
            if (q.mode == sbt_pkg::MD_DEF_TIMED || q.mode == sbt_pkg::MD_DEF_CONT) begin
               s.mode             = sbt_pkg::MD_MAIN;
               ev[sbt_pkg::IRQ_DEFEND] = 1'b1;
            // RL14 continuous defrost
            end else if (heat && q.hold >= sbt_pkg::CNT_W'(CONT_HOLD)) begin
               s.mode          = sbt_pkg::MD_DEF_CONT;
               ev[sbt_pkg::IRQ_DEF] = 1'b1;
            end else if (heat && q.hold >= sbt_pkg::CNT_W'(sbt_pkg::TEST_HOLD_T)) begin
               // RL11 coil gate
               if (coil_temp < sbt_pkg::COIL_EN_F) begin
                  s.mode          = sbt_pkg::MD_DEF_TIMED;
                  s.mtimer        = sbt_pkg::CNT_W'(DEF_MAX);
                  ev[sbt_pkg::IRQ_DEF] = 1'b1;
               end else begin
                  ev[sbt_pkg::IRQ_REFUSE] = 1'b1;
               end
            // RL4 test mode entry
            end else if (q.hold >= sbt_pkg::CNT_W'(sbt_pkg::TEST_HOLD_T)) begin
               ev[sbt_pkg::IRQ_TEST] = 1'b1;
               // RL5 clear short-cycle delay
               s.asc    = '0;
               s.minrun = '0;
               if (dem) begin
                  s.mode   = sbt_pkg::MD_TEST_SHOW;
                  s.mtimer = sbt_pkg::CNT_W'(sbt_pkg::SHOW_T);
               end else begin
                  // RL9 timed run
                  s.mode   = sbt_pkg::MD_TEST_RUN;
                  s.mtimer = sbt_pkg::CNT_W'(RUN_T);
                  s.comp   = 1'b1;
               end
            end
         end
      end
      // ==========================================================
      // compressor, fan, defrost
      s.defr = (s.mode == sbt_pkg::MD_DEF_TIMED) || (s.mode == sbt_pkg::MD_DEF_CONT);
      // RL6 forced run
      if (s.mode == sbt_pkg::MD_TEST_RUN || s.defr) begin
         s.comp = 1'b1;
      // RL7 hold off while letter shows
      end else if (s.mode != sbt_pkg::MD_TEST_SHOW && !q.comp && dem && q.asc == '0) begin
         s.comp   = 1'b1;
         s.minrun = sbt_pkg::CNT_W'(MINRUN_T);
      end else if (q.comp && !dem && q.minrun == '0) begin
         s.comp = 1'b0;
         s.asc  = sbt_pkg::CNT_W'(ASC_T);
      end
      s.fan = s.comp & ~s.defr;
      // ==========================================================
      // display
      flash     = dem & ~s.comp & ((s.asc != '0) | (s.minrun != '0));
      s.disp.hi = sbt_pkg::CH_BLANK;
      if (s.mode == sbt_pkg::MD_RECALL) begin
         s.disp.hi = s.rtag ? sbt_pkg::CH_F : hex_ch(code[7:4]);
         s.disp.lo = s.rtag ? sbt_pkg::CH_UC : hex_ch(code[3:0]);
      end else if (s.mode == sbt_pkg::MD_TEST_SHOW) begin
         s.disp.lo = sbt_pkg::CH_T;
      // RL12 defrost letter
      end else if (s.defr) begin
         s.disp.lo = sbt_pkg::CH_D;
      end else if (s.mode == sbt_pkg::MD_TEST_RUN && !dem) begin
         s.disp.lo = sbt_pkg::CH_UC;
      // RL16 flash during timers
      end else if (flash && s.blink) begin
         s.disp.lo = sbt_pkg::CH_BLANK;
      // RL15 demand letters
      end else if (demand.cool2) begin
         s.disp.lo = sbt_pkg::CH_UC;
      end else if (demand.cool1) begin
         s.disp.lo = sbt_pkg::CH_LC;
      end else if (demand.heat2) begin
         s.disp.lo = sbt_pkg::CH_UH;
      end else if (demand.heat1) begin
         s.disp.lo = sbt_pkg::CH_LH;
      // RL17 standby
      end else begin
         s.disp.lo = sbt_pkg::CH_ZERO;
      end
      // ==========================================================
      // bus slave
      s.wr = ~((avs_read | avs_write) & q.wr);
      if (avs_read && q.wr) begin
         unique case (avs_address)
            sbt_pkg::REG_STATUS: s.rdata = {23'h0, flash, q.rtag, q.defr, q.fan, q.comp, 1'b0, q.mode};
            sbt_pkg::REG_DISP:   s.rdata = {16'h0, q.disp};
            sbt_pkg::REG_FCOUNT: s.rdata = {28'h0, q.fcnt};
            sbt_pkg::REG_IRQ_ST: s.rdata = {27'h0, q.irq_st};
            sbt_pkg::REG_IRQ_EN: s.rdata = {27'h0, q.irq_en};
            default:             s.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && !q.wr) begin
         unique case (avs_address)
            sbt_pkg::REG_FPUSH: begin
               s.hist[q.wptr] = avs_writedata[7:0];
               s.wptr         = q.wptr + 1'b1;
               if (q.fcnt != (sbt_pkg::PTR_W+1)'(sbt_pkg::FAULT_DEPTH)) s.fcnt = q.fcnt + 1'b1;
            end
            sbt_pkg::REG_IRQ_EN:  s.irq_en = avs_writedata[sbt_pkg::IRQ_W-1:0];
            sbt_pkg::REG_IRQ_CLR: clr      = avs_writedata[sbt_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
      // set wins over clear
      s.irq_st = (q.irq_st & ~clr) | ev;
      s.irq    = |(s.irq_st & s.irq_en);
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         q      <= '0;
         q.mode <= sbt_pkg::MD_MAIN;
         q.wr   <= 1'b1;
         q.disp <= {sbt_pkg::CH_BLANK, sbt_pkg::CH_ZERO};
      end else begin
         q <= s;
      end
   end

   assign avs_readdata    = q.rdata;
   assign avs_waitrequest = q.wr;
   assign comp_on         = q.comp;
   assign fan_on          = q.fan;
   assign defrost_on      = q.defr;
   assign disp            = q.disp;
   assign irq             = q.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_recall_entry: assert property (rel && q.mode != sbt_pkg::MD_RECALL && q.used_a && q.used_t // RL1
      && q.hold >= sbt_pkg::CNT_W'(FC_HOLD) |=> q.mode == sbt_pkg::MD_RECALL && q.disp.hi == sbt_pkg::CH_F)
      else $error("recall not entered with tag");
   a_recall_first: assert property (rel && q.mode == sbt_pkg::MD_RECALL && q.rtag && !q.used_t // RL2
      |=> !q.rtag && q.ridx == '0) else $error("recall did not start at oldest");
   a_recall_exit: assert property (rel && q.mode == sbt_pkg::MD_RECALL && q.used_t // RL3
      |=> q.mode == sbt_pkg::MD_MAIN) else $error("test press did not leave recall");
   a_test_clears_asc: assert property ($rose(q.mode == sbt_pkg::MD_TEST_SHOW) // RL5
      |-> q.asc == '0 && !q.comp) else $error("short-cycle delay not cleared");
   a_show_then_run: assert property (q.mode == sbt_pkg::MD_TEST_SHOW && q.tick && q.mtimer == 1 // RL7
      |=> q.comp && q.fan && q.disp.lo != sbt_pkg::CH_T) else $error("no start after test letter");
   a_run_no_demand: assert property ($rose(q.mode == sbt_pkg::MD_TEST_RUN) && !$past(dem) // RL9
      |-> q.comp && q.disp.lo == sbt_pkg::CH_UC) else $error("test run without demand wrong");
   a_defrost_gate: assert property ($rose(q.mode == sbt_pkg::MD_DEF_TIMED) // RL11
      |-> $past(coil_temp) < sbt_pkg::COIL_EN_F) else $error("defrost test started on warm coil");
   a_defrost_letter: assert property (q.defr |-> q.disp.lo == sbt_pkg::CH_D && q.comp && !q.fan) // RL12
      else $error("defrost letter missing");
   a_defrost_stop: assert property (rel && q.defr && q.used_t && !q.used_a // RL13
      |=> !q.defr ##1 !q.defr) else $error("test press did not end defrost");
   a_standby_zero: assert property (q.mode == sbt_pkg::MD_MAIN && !$past(dem) // RL17
      |-> q.disp.lo == sbt_pkg::CH_ZERO) else $error("standby digit missing");

   c_recall: cover property (q.mode == sbt_pkg::MD_RECALL && !q.rtag);
   c_test_show: cover property (q.mode == sbt_pkg::MD_TEST_SHOW ##[1:1000] q.comp);
   c_cont_def: cover property (q.mode == sbt_pkg::MD_DEF_CONT);
   c_refuse: cover property (q.irq_st[sbt_pkg::IRQ_REFUSE]);
endmodule
`default_nettype wire

// File: bench/sbt_tech_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_tech_model #(
   parameter int unsigned TICK_CYC = 4
) (
   input  wire logic        sys_clk,
   input  wire logic        go,
   input  wire logic        want_a,
   input  wire logic        want_t,
   input  wire logic [15:0] ticks,
   output logic             advance_button,
   output logic             test_button,
   output logic             busy
);
   // ==========================================================
   // press, hold for a number of ticks, release
   initial begin
      advance_button = 1'b0;
      test_button    = 1'b0;
      busy           = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (go === 1'b1) begin
            busy           <= 1'b1;
            advance_button <= want_a;
            test_button    <= want_t;
            repeat ((ticks + 3) * TICK_CYC) @(posedge sys_clk);
            advance_button <= 1'b0;
            test_button    <= 1'b0;
            // settle: debounce and decision after release
            repeat (4 * TICK_CYC) @(posedge sys_clk);
            busy           <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/tb_service_button_test_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_service_button_test_mode_ctrl;
   localparam int unsigned TC = 4;
   logic                 sys_clk = 1'b0;
   logic                 resetn  = 1'b0;
   logic [4:0]           adr     = 5'h00;
   logic                 rd      = 1'b0;
   logic                 wr      = 1'b0;
   logic [31:0]          wd      = 32'h0;
   logic [31:0]          rdat;
   logic                 wreq;
   logic                 adv;
   logic                 tst;
   logic                 busy;
   logic                 go      = 1'b0;
   logic                 wa      = 1'b0;
   logic                 wt      = 1'b0;
   logic [15:0]          tk      = 16'h0;
   sbt_pkg::sbt_demand_t dem     = '0;
   logic [7:0]           coil    = 8'h30;
   logic                 comp;
   logic                 fan;
   logic                 defr;
   logic                 irq;
   sbt_pkg::sbt_disp_t   disp;
   logic [31:0]          r;
   int                   miscompares = 0;
   int                   n_tests     = 0;

   always #2 sys_clk = ~sys_clk;

   sbt_service_ctrl #(.TICK_CYC(TC), .FC_HOLD(16), .CONT_HOLD(1500), .RUN_T(20), .DEF_MAX(30),
      .MINRUN_T(10)) uut (
      .sys_clk(sys_clk), .resetn(resetn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .advance_button(adv),
      .test_button(tst), .demand(dem), .coil_temp(coil), .comp_on(comp), .fan_on(fan),
      .defrost_on(defr), .disp(disp), .irq(irq));

   sbt_tech_model #(.TICK_CYC(TC)) tech (
      .sys_clk(sys_clk), .go(go), .want_a(wa), .want_t(wt), .ticks(tk),
      .advance_button(adv), .test_button(tst), .busy(busy));

   // ==========================================================
   // common tasks
   task automatic end_sim;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      rd  <= !w;
      wr  <= w;
      adr <= a;
      wd  <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wreq !== 1'b0 && n < 100);
      chk(wreq, 1'b0, "waitrequest");
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic press(input logic a, input logic t, input int ticks);
      int n;
      n  = 0;
      wa <= a;
      wt <= t;
      tk <= 16'(ticks);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (2) @(posedge sys_clk);
      while (busy === 1'b1 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
   endtask

   task automatic wait_sig(input logic s, input logic v, input int ticks);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while ((s ? defr : comp) !== v && n < ticks * TC);
      chk(s ? defr : comp, v, "wait output");
   endtask

   task automatic set_coil(input logic [7:0] c);
      @(posedge sys_clk);
      coil <= c;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      chk({disp.hi, disp.lo}, {sbt_pkg::CH_BLANK, sbt_pkg::CH_ZERO}, "standby");
      chk({comp, fan, defr, irq}, 4'h0, "outputs");
      bus(1'b0, 5'h1C, 32'h0);
      chk(r, 32'h0, "unmapped");
      bus(1'b0, sbt_pkg::REG_FCOUNT, 32'h0);
      chk(r[3:0], 4'h0, "history empty");
   endtask

   task automatic t_recall;
      bus(1'b1, sbt_pkg::REG_FPUSH, 32'h12);
      bus(1'b1, sbt_pkg::REG_FPUSH, 32'h34);
      bus(1'b0, sbt_pkg::REG_FCOUNT, 32'h0);
      chk(r[3:0], 4'h2, "count");
      press(1'b1, 1'b1, 1100);
      chk({disp.hi, disp.lo}, {sbt_pkg::CH_F, sbt_pkg::CH_UC}, "menu tag");
      press(1'b1, 1'b0, 20);
      chk({disp.hi, disp.lo}, 16'h3132, "oldest");
      press(1'b1, 1'b0, 20);
      chk({disp.hi, disp.lo}, 16'h3334, "next");
      press(1'b0, 1'b1, 20);
      bus(1'b0, sbt_pkg::REG_STATUS, 32'h0);
      chk(r[2:0], 3'h0, "main menu");
   endtask

   task automatic t_test_idle;
      bus(1'b1, sbt_pkg::REG_IRQ_EN, 32'h2);
      press(1'b0, 1'b1, 1100);
      chk({comp, fan}, 2'h3, "run without demand");
      chk(disp.lo, sbt_pkg::CH_UC, "steady C");
      chk(irq, 1'b1, "irq raised");
      bus(1'b1, sbt_pkg::REG_IRQ_CLR, 32'h2);
      chk(irq, 1'b0, "irq cleared");
      bus(1'b1, sbt_pkg::REG_IRQ_EN, 32'h0);
      wait_sig(1'b0, 1'b0, 30);
   endtask

   task automatic t_flash_test;
      int nb;
      int nc;
      logic [3:0] dv [4];
      logic [7:0] ch [4];
      nb = 0;
      nc = 0;
      dv = '{4'h8, 4'h4, 4'h2, 4'h1};
      ch = '{sbt_pkg::CH_UC, sbt_pkg::CH_LC, sbt_pkg::CH_UH, sbt_pkg::CH_LH};
      @(posedge sys_clk);
      dem <= sbt_pkg::sbt_demand_t'(4'h4);
      repeat (700 * TC) begin
         @(negedge sys_clk);
         nb += int'(disp.lo === sbt_pkg::CH_BLANK);
         nc += int'(disp.lo === sbt_pkg::CH_LC);
      end
      chk({nb > 0, nc > 0, comp}, 3'h6, "flash");
      press(1'b0, 1'b1, 1100);
      chk({comp, disp.lo}, {1'b0, sbt_pkg::CH_T}, "test letter");
      wait_sig(1'b0, 1'b1, 600);
      nb = 0;
      repeat (600 * TC) begin
         @(negedge sys_clk);
         nb += int'(disp.lo !== sbt_pkg::CH_LC || comp !== 1'b1);
      end
      chk(nb, 0, "steady run");
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         dem <= sbt_pkg::sbt_demand_t'(dv[i]);
         repeat (3) @(negedge sys_clk);
         chk(disp.lo, ch[i], "demand letter");
      end
   endtask

   task automatic t_defrost;
      press(1'b0, 1'b1, 1100);
      chk({defr, fan, disp.lo}, {2'h2, sbt_pkg::CH_D}, "defrost");
      set_coil(8'h40);
      wait_sig(1'b1, 1'b0, 10);
      set_coil(8'h30);
      press(1'b0, 1'b1, 1100);
      repeat (20 * TC) @(negedge sys_clk);
      chk(defr, 1'b1, "before limit");
      wait_sig(1'b1, 1'b0, 20);
      set_coil(8'h46);
      press(1'b0, 1'b1, 1100);
      chk({defr, irq}, 2'h0, "refused masked");
      bus(1'b0, sbt_pkg::REG_IRQ_ST, 32'h0);
      chk(r[3], 1'b1, "refuse status");
      bus(1'b1, sbt_pkg::REG_IRQ_EN, 32'h8);
      chk(irq, 1'b1, "irq enabled");
      bus(1'b1, sbt_pkg::REG_IRQ_CLR, 32'h8);
      chk(irq, 1'b0, "irq cleared");
      set_coil(8'h30);
      press(1'b0, 1'b1, 1100);
      chk(defr, 1'b1, "defrost again");
      press(1'b0, 1'b1, 20);
      chk(defr, 1'b0, "test ends");
      press(1'b0, 1'b1, 1600);
      repeat (100 * TC) @(negedge sys_clk);
      chk({defr, disp.lo}, {1'b1, sbt_pkg::CH_D}, "continuous");
      press(1'b0, 1'b1, 20);
      chk(defr, 1'b0, "continuous ends");
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      t_reset;
      t_recall;
      t_test_idle;
      t_flash_test;
      t_defrost;
      end_sim;
   end

   initial begin
      repeat (90000) @(posedge sys_clk);
      miscompares++;
      end_sim;
   end
endmodule
`default_nettype wire
